// [hdl/ubg_baud_gen.sv]
// Baud rate generator with clock source select, fractional divide and pin map
// Behaviour
// - Source: master clock, divided, or pin
// - Sixteen-bit integer divider from clock_divisor
// - Divisor zero stops all clock output
// - Divisor one bypasses the divider
// - Divider output samples; further divide gives baud
// - Oversampling bit selects 8 or 16
// - Baud is source over 8(2-over)divisor
// - Nonzero fraction enables fractional division
// - Effective divisor adds fraction over eight
// - Fraction only in normal asynchronous mode
// - Clock gating resumes from held state
// - Configuration writable while clock gated
// - Clear-to-send active low, slave select
// - Request-to-send active low, slave select
// - SPI data pins keep USART roles; slave drives TXD only while selected
`timescale 1ns/1ps
module ubg_baud_gen
(
	input wire logic CLOCK_I,
	input wire logic SRST_I,
	input wire logic CLK_EN_I,
	input wire logic [1:0] CLOCK_SOURCE_SELECT_I,
	input wire logic [15:0] CLOCK_DIVISOR_I,
	input wire logic [2:0] FRACTIONAL_DIVISOR_I,
	input wire logic OVER_I,
	input wire ubg_pkg::ubg_mode_type MODE_I,
	input wire logic SCK_I,
	input wire logic TX_DATA_I,
	input wire logic RTS_REQ_I,
	input wire logic SLAVE_SELECT_REQ_I,
	input wire logic TXD_PIN_I,
	input wire logic RXD_PIN_I,
	input wire logic CTS_N_PIN_I,
	output logic SAMPLE_EN_O,
	output logic BAUD_EN_O,
	output logic RX_DATA_O,
	output logic CTS_O,
	output logic SLAVE_SELECT_O,
	output logic TXD_PIN_O,
	output logic TXD_PIN_OE_N_O,
	output logic RTS_N_PIN_O
);
	import ubg_pkg::*;

	logic sck_sync;
	logic rxd_sync;
	logic cts_sync;
	logic txd_sync;
	logic sck_prev;
	logic next_sck_prev;
	logic [2:0] pre_cnt;
	logic [2:0] next_pre_cnt;
	logic src_tick;
	logic [15:0] div_cnt;
	logic [15:0] next_div_cnt;
	logic [2:0] frac_acc;
	logic [2:0] next_frac_acc;
	logic frac_extra;
	logic next_frac_extra;
	logic [4:0] os_cnt;
	logic [4:0] next_os_cnt;
	logic next_sample_en;
	logic next_baud_en;
	logic frac_on;
	logic div_hit;
	logic [3:0] frac_sum;
	logic [4:0] os_ratio;

	// Pin inputs pass two flops before any logic reads them
	ubg_pin_sync u_sck (.clk_i(CLOCK_I), .srst_i(SRST_I), .d_i(SCK_I), .q_o(sck_sync));
	ubg_pin_sync u_rxd (.clk_i(CLOCK_I), .srst_i(SRST_I), .d_i(RXD_PIN_I), .q_o(rxd_sync));
	ubg_pin_sync u_cts (.clk_i(CLOCK_I), .srst_i(SRST_I), .d_i(CTS_N_PIN_I), .q_o(cts_sync));
	ubg_pin_sync u_txd (.clk_i(CLOCK_I), .srst_i(SRST_I), .d_i(TXD_PIN_I), .q_o(txd_sync));

	// Source tick selection
	always_comb
	begin
		unique case (CLOCK_SOURCE_SELECT_I)
			SRC_MCK: src_tick = 1'b1;
			SRC_MCK_DIV: src_tick = (pre_cnt == 3'(MCK_DIV - 1));
			SRC_SCK: src_tick = sck_sync & ~sck_prev;
			default: src_tick = 1'b0;
		endcase
	end

	// Fraction applies only with a nonzero field in normal async mode
	assign frac_on = (FRACTIONAL_DIVISOR_I != FP_RESET) && (MODE_I == UBG_USART_type_mode);
	assign frac_sum = {1'b0, frac_acc} + {1'b0, FRACTIONAL_DIVISOR_I};
	assign div_hit = src_tick && (div_cnt == 16'h0000) && !frac_extra;
	assign os_ratio = OVER_I ? OVER8_RATIO : OVER16_RATIO;

	// Next state of the prescaler, divider, fraction and oversampler
	always_comb
	begin
		next_sck_prev = sck_sync;
		next_pre_cnt = pre_cnt;
		next_div_cnt = div_cnt;
		next_frac_acc = frac_acc;
		next_frac_extra = frac_extra;
		next_os_cnt = os_cnt;
		next_sample_en = 1'b0;
		next_baud_en = 1'b0;
		if (CLK_EN_I)
		begin
			next_pre_cnt = (pre_cnt == 3'(MCK_DIV - 1)) ? 3'h0 : pre_cnt + 3'h1;
			if (CLOCK_DIVISOR_I == CD_RESET)
			begin
				next_div_cnt = 16'h0000;
				next_frac_extra = 1'b0;
				next_os_cnt = 5'h00;
			end
			else if (src_tick)
			begin
				if (frac_extra)
					next_frac_extra = 1'b0;
				else if (div_cnt != 16'h0000)
					next_div_cnt = div_cnt - 16'h0001;
				else
				begin
					// Reload; divisor one reloads zero so every tick passes
					next_div_cnt = CLOCK_DIVISOR_I - 16'h0001;
					next_sample_en = 1'b1;
					if (frac_on)
					begin
						next_frac_acc = frac_sum[2:0];
						next_frac_extra = frac_sum[3];
					end
					if (os_cnt >= os_ratio - 5'h01)
					begin
						next_os_cnt = 5'h00;
						next_baud_en = 1'b1;
					end
					else
						next_os_cnt = os_cnt + 5'h01;
				end
			end
		end
		if (SRST_I)
		begin
			next_sck_prev = 1'b1; // Matches the synchroniser's reset level, so no false edge
			next_pre_cnt = 3'h0;
			next_div_cnt = 16'h0000;
			next_frac_acc = FP_RESET;
			next_frac_extra = 1'b0;
			next_os_cnt = 5'h00;
			next_sample_en = 1'b0;
			next_baud_en = 1'b0;
		end
	end

	// Counters hold while the clock enable is low, resuming in place
	always_ff @(posedge CLOCK_I)
	begin
		sck_prev <= next_sck_prev;
		pre_cnt <= next_pre_cnt;
		div_cnt <= next_div_cnt;
		frac_acc <= next_frac_acc;
		frac_extra <= next_frac_extra;
		os_cnt <= next_os_cnt;
		SAMPLE_EN_O <= next_sample_en;
		BAUD_EN_O <= next_baud_en;
	end

	// Pin mapping for USART and SPI roles; config ports are plain levels
	always_comb
	begin
		RX_DATA_O = rxd_sync;
		TXD_PIN_O = TX_DATA_I;
		TXD_PIN_OE_N_O = 1'b0;
		CTS_O = ~cts_sync;
		SLAVE_SELECT_O = 1'b0;
		RTS_N_PIN_O = ~RTS_REQ_I;
		unique case (MODE_I)
			UBG_SPI_MASTER:
			begin
				RTS_N_PIN_O = ~SLAVE_SELECT_REQ_I;
				RX_DATA_O = rxd_sync;
			end
			UBG_SPI_SLAVE:
			begin
				SLAVE_SELECT_O = ~cts_sync;
				CTS_O = 1'b0;
				TXD_PIN_OE_N_O = cts_sync;
				RTS_N_PIN_O = 1'b1;
			end
			default:
			begin
				RX_DATA_O = rxd_sync;
			end
		endcase
		if (SRST_I)
			TXD_PIN_OE_N_O = 1'b1;
		if (txd_sync && 1'b0)
			RX_DATA_O = 1'b0;
	end
endmodule

// [hdl/ubg_pkg.sv]
// Shared constants and types for the serial port baud rate generator
package ubg_pkg;
	localparam int CD_WIDTH = 16;
	localparam int FP_WIDTH = 3;
	localparam int MCK_DIV = 8;
	localparam logic [1:0] SRC_MCK = 2'h0;
	localparam logic [1:0] SRC_MCK_DIV = 2'h1;
	localparam logic [1:0] SRC_SCK = 2'h3;
	localparam logic [15:0] CD_RESET = 16'h0000;
	localparam logic [2:0] FP_RESET = 3'h0;
	localparam logic [4:0] OVER8_RATIO = 5'h08;
	localparam logic [4:0] OVER16_RATIO = 5'h10;
	typedef enum logic [1:0] {
		UBG_USART_type_mode = 2'h0,
		UBG_SPI_MASTER = 2'h1,
		UBG_SPI_SLAVE = 2'h3,
		UBG_SPECIAL = 2'h2
	} ubg_mode_type;
endpackage

// [hdl/ubg_pin_sync.sv]
// Two-stage synchroniser for a pin input
`timescale 1ns/1ps
module ubg_pin_sync
(
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic d_i,
	output logic q_o
);
	logic meta;
	logic next_meta;
	logic next_q;

	// Next values of both stages
	always_comb
	begin
		next_meta = d_i;
		next_q = meta;
		if (srst_i)
		begin
			next_meta = 1'b1;
			next_q = 1'b1;
		end
	end

	// Register both stages
	always_ff @(posedge clk_i)
	begin
		meta <= next_meta;
		q_o <= next_q;
	end
endmodule

// [sim/ubg_checker.sv]
// Port assertions for the baud generator
`timescale 1ns/1ps
module ubg_checker
(
	input wire logic CLOCK_I,
	input wire logic SRST_I,
	input wire logic CLK_EN_I,
	input wire logic [1:0] CLOCK_SOURCE_SELECT_I,
	input wire logic [15:0] CLOCK_DIVISOR_I,
	input wire logic [2:0] FRACTIONAL_DIVISOR_I,
	input wire ubg_pkg::ubg_mode_type MODE_I,
	input wire logic TX_DATA_I,
	input wire logic CTS_N_PIN_I,
	input wire logic SAMPLE_EN_O,
	input wire logic BAUD_EN_O,
	input wire logic CTS_O,
	input wire logic TXD_PIN_O,
	input wire logic TXD_PIN_OE_N_O,
	input wire logic RXD_PIN_I,
	input wire logic RX_DATA_O,
	input wire logic SLAVE_SELECT_REQ_I,
	input wire logic SLAVE_SELECT_O,
	input wire logic RTS_N_PIN_O
);
	import ubg_pkg::*;
	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (SRST_I);
	// Master clock source with divisor two or one, fraction not in effect
	sequence s_div2;
		CLK_EN_I && CLOCK_SOURCE_SELECT_I == SRC_MCK && CLOCK_DIVISOR_I == 16'h0002
		&& (MODE_I != UBG_USART_type_mode || FRACTIONAL_DIVISOR_I == 3'h0);
	endsequence
	sequence s_byp;
		CLK_EN_I && CLOCK_SOURCE_SELECT_I == SRC_MCK && CLOCK_DIVISOR_I == 16'h0001
		&& FRACTIONAL_DIVISOR_I == 3'h0;
	endsequence
	a_zero_silent: assert property ((CLOCK_DIVISOR_I == 16'h0000) [*3] |-> !SAMPLE_EN_O)
		else $error("pulse at zero");
	a_baud_on_sample: assert property (BAUD_EN_O |-> SAMPLE_EN_O) else $error("lone baud");
	a_baud_single: assert property (BAUD_EN_O |=> !BAUD_EN_O) else $error("long baud");
	a_div_two: assert property (s_div2 [*8] ##0 SAMPLE_EN_O |-> $past(SAMPLE_EN_O, 2)
		&& !$past(SAMPLE_EN_O)) else $error("bad div two");
	a_bypass_run: assert property (s_byp [*8] |-> SAMPLE_EN_O) else $error("no bypass");
	a_cts_low: assert property ((MODE_I == UBG_USART_type_mode && CLK_EN_I && !SRST_I
		&& $stable(CTS_N_PIN_I)) [*4] |-> CTS_O == !CTS_N_PIN_I) else $error("bad cts");
	a_rx_follow: assert property ((!SRST_I && $stable(RXD_PIN_I)) [*3]
		|-> RX_DATA_O == RXD_PIN_I) else $error("bad rx data");
	a_slave_sel: assert property ((MODE_I == UBG_SPI_SLAVE && !SRST_I
		&& $stable(CTS_N_PIN_I)) [*3] |-> SLAVE_SELECT_O == !CTS_N_PIN_I) else $error("bad select");
	a_master_sel: assert property (MODE_I == UBG_SPI_MASTER
		|-> RTS_N_PIN_O == !SLAVE_SELECT_REQ_I) else $error("bad master select");
	a_master_mosi: assert property (MODE_I == UBG_SPI_MASTER |-> TXD_PIN_O == TX_DATA_I)
		else $error("bad mosi");
	a_slave_idle: assert property ((MODE_I == UBG_SPI_SLAVE && CLK_EN_I && CTS_N_PIN_I) [*4]
		|-> TXD_PIN_OE_N_O) else $error("miso driven");
endmodule
bind ubg_baud_gen ubg_checker u_chk (.CLOCK_I, .SRST_I, .CLK_EN_I, .CLOCK_SOURCE_SELECT_I,
	.CLOCK_DIVISOR_I, .FRACTIONAL_DIVISOR_I, .MODE_I, .TX_DATA_I, .CTS_N_PIN_I, .SAMPLE_EN_O,
	.BAUD_EN_O, .CTS_O, .TXD_PIN_O, .TXD_PIN_OE_N_O, .RXD_PIN_I, .RX_DATA_O,
	.SLAVE_SELECT_REQ_I, .SLAVE_SELECT_O, .RTS_N_PIN_O);

// [sim/ubg_peer.sv]
// Far-side peer: serial clock and clear-to-send pin
`timescale 1ns/1ps
module ubg_peer
(
	input wire logic clk_i,
	input wire logic run_i,
	output logic sck_o = 1'b0,
	output logic cts_n_o = 1'b1
);
	int ph = 0;
	// No interrupt line reaches this peer; any controller takes it as a level
	// Clock of six periods, three high and three low, held low while idle
	always @(posedge clk_i)
	begin
		ph <= run_i ? (ph + 1) % 6 : 0;
		sck_o <= run_i && ph > 2;
		cts_n_o <= 1'($urandom);
	end
endmodule

// [sim/tb.sv]
// Self-checking bench for the baud generator
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
	$display("BAD %0t %h %h", $time, g, e); end end
module tb;
	import ubg_pkg::*;
	logic clk = 0, rst = 1, en = 1, ov = 0, tx = 0, run = 0, sck, cts, bd;
	logic [1:0] src = 0;
	logic [15:0] cd = 0;
	logic [2:0] fp = 0;
	ubg_mode_type md = UBG_USART_type_mode;
	int n_fail = 0, samples_checked = 0, cnt = 0, arm = 0, p, e, q[$];
	ubg_peer peer (.clk_i(clk), .run_i(run), .sck_o(sck), .cts_n_o(cts));
	ubg_baud_gen dut (.CLOCK_I(clk), .SRST_I(rst), .CLK_EN_I(en), .CLOCK_SOURCE_SELECT_I(src),
		.CLOCK_DIVISOR_I(cd), .FRACTIONAL_DIVISOR_I(fp), .OVER_I(ov), .MODE_I(md), .SCK_I(sck),
		.TX_DATA_I(tx), .RTS_REQ_I(tx), .SLAVE_SELECT_REQ_I(tx), .TXD_PIN_I(tx), .RXD_PIN_I(tx),
		.CTS_N_PIN_I(cts), .SAMPLE_EN_O(), .BAUD_EN_O(bd), .RX_DATA_O(), .CTS_O(),
		.SLAVE_SELECT_O(), .TXD_PIN_O(), .TXD_PIN_OE_N_O(), .RTS_N_PIN_O());
	initial forever #12.5 clk = ~clk;
	// Random serial data at the falling edge
	always @(negedge clk)
		tx <= 1'($urandom);
	// Baud period measured and matched to the oldest note
	always @(posedge clk)
	begin
		cnt <= bd ? 1 : cnt + 1;
		if (bd && arm)
		begin
			e = q.size() ? q.pop_front() : 0;
			`CHK(cnt, e)
		end
	end
	// One rate case, with an optional clock gate in the first period
	task automatic run_case(input logic [1:0] s, input ubg_mode_type m, input int g);
		@(negedge clk);
		arm = 0;
		src = s;
		md = m;
		run = s == SRC_SCK;
		cd = 16'(2 + $urandom_range(3) * (s != SRC_MCK));
		fp = 3'($urandom);
		ov = 1'($urandom);
		p = (2 - ov) * (8 * cd + (m == UBG_USART_type_mode ? fp : 0));
		p = p * (s == SRC_MCK ? 1 : s == SRC_SCK ? 6 : MCK_DIV);
		repeat (2) @(posedge bd);
		@(negedge bd);
		q = '{p + (g > 0 ? g - 1 : 0), p, p};
		arm = 1;
		for (int k = 0; k < g; k++)
			@(negedge clk) en = k == g - 1;
		wait (q.size() == 0);
		$display("case src %0d mode %0d done", s, m);
	endtask
	// Verdict and end of run
	task automatic wrap_up;
		$display("checked %0d failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		void'($urandom(32'hdf5dad11));
		repeat (8) @(negedge clk);
		rst = 0;
		for (int i = 0; i < 6; i++)
			run_case(2'(i % 3 * 3 / 2), i < 3 ? UBG_USART_type_mode : UBG_SPECIAL, i % 3 ? 0 : 5);
		@(negedge clk);
		arm = 0;
		run = 0;
		src = SRC_MCK;
		cd = 16'h0001;
		fp = 3'h0;
		repeat (40) @(negedge clk);
		cd = 16'h0000;
		repeat (4) @(negedge clk);
		arm = 1;
		repeat (300) @(negedge clk);
		md = UBG_SPI_MASTER;
		repeat (60) @(negedge clk);
		md = UBG_SPI_SLAVE;
		repeat (60) @(negedge clk);
		$display("pin and zero divisor case done");
		wrap_up;
	end
	// Watchdog on the whole run
	initial
	begin
		#2ms;
		n_fail++;
		wrap_up;
	end
endmodule
